// ==== design/omb_pkg.sv ====
// Shared constants and types for the multiply, divide, bit test and skip unit
package omb_pkg;

	// ======================================================================
	// Widths
	localparam int OMB_DATA_W  = 16;            // Host word width
	localparam int OMB_MAG_W   = 15;            // Magnitude bits below the sign
	localparam int OMB_CNT_W   = 5;             // Shift counter width
	localparam int OMB_SEL_W   = 4;             // Bit-test position field

	// ======================================================================
	// Shift counts
	localparam logic [4:0] OMB_MUL_STEPS = 5'h10; // One add-and-shift per multiplier bit
	localparam logic [4:0] OMB_DIV_STEPS = 5'h0f; // One compare-and-shift per quotient bit

	// ======================================================================
	// Skip-on-register-equal register select codes
	localparam logic [1:0] OMB_SRE_A = 2'h0;
	localparam logic [1:0] OMB_SRE_B = 2'h1;
	localparam logic [1:0] OMB_SRE_X = 2'h2;

	// ======================================================================
	// Sequencer states
	typedef enum logic [2:0] {MD_IDLE, MD_LOAD, MD_STEP, MD_FIX, MD_DONE} omb_mul_state_t;
	typedef enum logic [2:0] {DV_IDLE, DV_LOAD, DV_CHECK, DV_STEP, DV_WRITE} omb_div_state_t;
	typedef enum logic [1:0] {TS_IDLE, TS_GATE, TS_TEST, TS_EXIT} omb_test_state_t;

endpackage

// ==== design/omb_shift_counter.sv ====
// Shift counter shared by the multiply and divide sequencers
`timescale 1ns/10ps
module omb_shift_counter import omb_pkg::*; #(
	parameter int CNT_W = OMB_CNT_W
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             clkEn,
	// Control
	input  wire logic             clear,
	input  wire logic             shiftEn,
	input  wire logic [CNT_W-1:0] limit,
	// Status
	output logic                  lastShift
);

	if (CNT_W < 2) begin : g_bad_width
		$error("omb_shift_counter: CNT_W too small");
	end

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;

	// ======================================================================
	// Counting
	// Last shift is flagged combinationally so the sequencer leaves on time
	assign lastShift = shiftEn && (count_q == CNT_W'(limit - 1'b1));

	always_comb begin
		count_d = count_q;
		if (clear) begin
			count_d = '0;
		end else if (shiftEn) begin
			count_d = CNT_W'(count_q + 1'b1);
		end
	end

	// Register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count_q <= '0;
		end else if (clkEn) begin
			count_q <= count_d;
		end
	end

endmodule // omb_shift_counter

// ==== design/omb_test_seq.sv ====
// Shared sequencer for the bit test jump and skip on register equal
`timescale 1ns/10ps
module omb_test_seq import omb_pkg::*; #(
	parameter int DATA_W = OMB_DATA_W
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 clkEn,
	// Instruction starts and fields
	input  wire logic                 startBt,
	input  wire logic                 startSre,
	input  wire logic [OMB_SEL_W-1:0] bitSel,
	input  wire logic                 bitRegSelB,
	input  wire logic                 bitExpect,
	input  wire logic [1:0]           sreSel,
	// Host adder view
	input  wire logic [DATA_W-1:0]    adderASideInN,
	input  wire logic                 adderInputsEqual,
	// Host control
	output logic                      gateAN_q,
	output logic                      gateBN_q,
	output logic                      gateXN_q,
	output logic                      jumpN_q,
	output logic                      skipN_q,
	output logic                      pIncN_q,
	output logic                      testBusy_q
);

	if (DATA_W != (1 << OMB_SEL_W)) begin : g_bad_width
		$error("omb_test_seq: DATA_W must match the bit select field");
	end

	omb_test_state_t state_q, state_d;
	logic isBt_q, isBt_d;
	logic gateAN_d, gateBN_d, gateXN_d, jumpN_d, skipN_d, pIncN_d;
	logic bitMatch;

	// Adder A side is active low, so the tested bit is inverted back
	assign bitMatch = (~adderASideInN[bitSel]) == bitExpect;

	// ======================================================================
	// Next state and host strobes
	always_comb begin
		state_d  = state_q;
		isBt_d   = isBt_q;
		gateAN_d = 1'b1;
		gateBN_d = 1'b1;
		gateXN_d = 1'b1;
		jumpN_d  = 1'b1;
		skipN_d  = 1'b1;
		pIncN_d  = 1'b1;
		unique case (state_q)
			TS_IDLE: begin
				if (startBt || startSre) begin
					state_d = TS_GATE;
					isBt_d  = startBt;
				end
			end
			TS_GATE: state_d = TS_TEST;
			TS_TEST: begin
				state_d = TS_EXIT;
				if (isBt_q) begin
					jumpN_d = !bitMatch;
					pIncN_d = bitMatch;
				end else begin
					skipN_d = !adderInputsEqual;
				end
			end
			TS_EXIT: state_d = TS_IDLE;
		endcase
		// Selected register stays on the adder while it is examined
		if (state_d == TS_GATE || state_d == TS_TEST) begin
			if (isBt_d) begin
				gateAN_d = bitRegSelB;
				gateBN_d = !bitRegSelB;
			end else begin
				gateAN_d = (sreSel != OMB_SRE_A);
				gateBN_d = (sreSel != OMB_SRE_B);
				gateXN_d = (sreSel != OMB_SRE_X);
			end
		end
	end

	// Register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q    <= TS_IDLE;
			isBt_q     <= 1'b0;
			gateAN_q   <= 1'b1;
			gateBN_q   <= 1'b1;
			gateXN_q   <= 1'b1;
			jumpN_q    <= 1'b1;
			skipN_q    <= 1'b1;
			pIncN_q    <= 1'b1;
			testBusy_q <= 1'b0;
		end else if (clkEn) begin
			state_q    <= state_d;
			isBt_q     <= isBt_d;
			gateAN_q   <= gateAN_d;
			gateBN_q   <= gateBN_d;
			gateXN_q   <= gateXN_d;
			jumpN_q    <= jumpN_d;
			skipN_q    <= skipN_d;
			pIncN_q    <= pIncN_d;
			testBusy_q <= (state_d != TS_IDLE);
		end
	end

	// ======================================================================
	// Checks
	a_bt_jump_match: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && state_q == TS_TEST && isBt_q |=> (jumpN_q == !$past(bitMatch)))
		else $error("bit test jump does not follow the bit match");
	a_sre_skip_eq: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && state_q == TS_TEST && !isBt_q |=> (skipN_q == !$past(adderInputsEqual)))
		else $error("skip does not follow adder equality");
	a_test_walk: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && state_q == TS_IDLE && startBt |=> state_q == TS_GATE && testBusy_q)
		else $error("test sequencer did not leave idle on start");

endmodule // omb_test_seq

// ==== design/omb_unit.sv ====
// Multiply, divide, bit test and register-equal skip execution unit
//
// Behaviour
// - Multiply adds multiplicand into partial result, shifting it right each step.
// - Divide compares magnitudes, subtracts where needed, shifts quotient and remainder left.
// - Multiply yields operand times B plus old A; high half A, low half B.
// - After multiply A sign holds product sign, B sign is zero.
// - Product magnitude of two to the thirtieth sets overflow.
// - Divide A:B by operand; quotient to B, remainder to A.
// - After divide B sign is quotient sign, A sign is dividend sign.
// - Quotient magnitude beyond 32,767 sets overflow, so -32,768 also sets it.
// - Overflow raises an enable; host then sets its overflow flip-flop.
// - Skip two addresses when selected A, B or X equals the operand.
// - Bit test examines one bit of A or B; jump only on match.
// - Multiply sequencer steps states and enables the shared shift counter.
// - Divide sequencer steps states and enables the shared shift counter.
// - Shift counter counts shifts and tells control when to finish.
// - One shared sequencer times bit test and skip, driving host control.
// - Bit test decodes bit and register, tests it, signals result.
// - Skip control decodes compared register and issues host controls.
// - Unit drives two adder select enables, low pair and high pair.
// - Overflow is signalled by an active low overflow set enable.
`timescale 1ns/10ps
module omb_unit import omb_pkg::*; #(
	parameter int DATA_W = OMB_DATA_W
) (
	// Clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 clkEn,
	// Instruction decodes, active low
	input  wire logic                 multiplyDecodeN,
	input  wire logic                 divideDecodeN,
	input  wire logic                 bitTestJumpN,
	input  wire logic                 skipOnRegisterEqualN,
	// Instruction fields
	input  wire logic [OMB_SEL_W-1:0] bitSel,
	input  wire logic                 bitRegSelB,
	input  wire logic                 bitExpect,
	input  wire logic [1:0]           sreSel,
	// Host data and flags
	input  wire logic [DATA_W-1:0]    aReg,
	input  wire logic [DATA_W-1:0]    bReg,
	input  wire logic [DATA_W-1:0]    memOperand,
	input  wire logic [DATA_W-1:0]    adderASideInN,
	input  wire logic                 adderInputsEqual,
	input  wire logic                 bRegIsZero,
	// Results towards the A and B register inputs
	output logic [DATA_W-1:0]         aResult_q,
	output logic [DATA_W-1:0]         bResult_q,
	output logic                      aLoadN_q,
	output logic                      bLoadN_q,
	// Host control
	output logic                      overflowSetEnableN_q,
	output logic                      adderSelectPairLowEnN_q,
	output logic                      adderSelectPairHighEnN_q,
	output logic                      mdBusy_q,
	// Test and skip control
	output logic                      gateAN_q,
	output logic                      gateBN_q,
	output logic                      gateXN_q,
	output logic                      jumpN_q,
	output logic                      skipN_q,
	output logic                      pIncN_q,
	output logic                      testBusy_q
);

	if (DATA_W != OMB_DATA_W) begin : g_bad_width
		$error("omb_unit: datapath is built for a 16-bit word");
	end

	// ======================================================================
	// Decode edge detection
	// Decodes are levels held for the whole instruction; start on the fall only
	logic [3:0] decPrevN_q;
	logic       startMul, startDiv, startBt, startSre;

	assign startMul = !multiplyDecodeN && decPrevN_q[0];
	assign startDiv = !divideDecodeN && decPrevN_q[1];
	assign startBt  = !bitTestJumpN && decPrevN_q[2];
	assign startSre = !skipOnRegisterEqualN && decPrevN_q[3];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			decPrevN_q <= 4'hf;
		end else if (clkEn) begin
			decPrevN_q <= {skipOnRegisterEqualN, bitTestJumpN, divideDecodeN, multiplyDecodeN};
		end
	end

	// ======================================================================
	// Shared shift counter
	omb_mul_state_t   mulState_q, mulState_d;
	omb_div_state_t   divState_q, divState_d;
	logic             shiftEn, shiftClear, shiftLast;
	logic [OMB_CNT_W-1:0] shiftLimit;

	assign shiftEn    = (mulState_q == MD_STEP) || (divState_q == DV_STEP);
	assign shiftClear = (mulState_q == MD_LOAD) || (divState_q == DV_LOAD);
	assign shiftLimit = (divState_q == DV_STEP) ? OMB_DIV_STEPS : OMB_MUL_STEPS;

	omb_shift_counter #(.CNT_W(OMB_CNT_W)) u_shift (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.clear     (shiftClear),
		.shiftEn   (shiftEn),
		.limit     (shiftLimit),
		.lastShift (shiftLast)
	);

	// ======================================================================
	// Multiply datapath and sequencer
	logic [DATA_W-1:0] mcand_q, mcand_d, mq_q, mq_d, acc_q, acc_d, origA_q, origA_d;
	logic              prodNeg_q, prodNeg_d;
	logic [DATA_W:0]   mulSum;
	logic [2*DATA_W-1:0] prodMag;
	logic [2*DATA_W+1:0] prodSigned, mulRes;
	logic              mulOvf;

	// Add-then-shift-right step on magnitudes
	assign mulSum = {1'b0, acc_q} + {1'b0, (mq_q[0] ? mcand_q : '0)};
	assign prodMag    = {acc_q, mq_q};
	assign prodSigned = prodNeg_q ? (~{2'b00, prodMag} + 1'b1) : {2'b00, prodMag};
	assign mulRes     = prodSigned + {{(DATA_W+2){origA_q[DATA_W-1]}}, origA_q};
	// Result must fit sign plus thirty magnitude bits
	assign mulOvf = (mulRes[2*DATA_W+1:2*DATA_W-2] != 4'h0)
		&& (mulRes[2*DATA_W+1:2*DATA_W-2] != 4'hf);

	always_comb begin
		mulState_d = mulState_q;
		mcand_d    = mcand_q;
		mq_d       = mq_q;
		acc_d      = acc_q;
		origA_d    = origA_q;
		prodNeg_d  = prodNeg_q;
		unique case (mulState_q)
			// A decode while the other operation runs is ignored; the counter is shared
			MD_IDLE: if (startMul && divState_q == DV_IDLE) mulState_d = MD_LOAD;
			MD_LOAD: begin
				mcand_d   = memOperand[DATA_W-1] ? DATA_W'(-memOperand) : memOperand;
				mq_d      = bReg[DATA_W-1] ? DATA_W'(-bReg) : bReg;
				acc_d     = '0;
				origA_d   = aReg;
				prodNeg_d = memOperand[DATA_W-1] ^ bReg[DATA_W-1];
				// A zero multiplier needs no adds; only old A remains
				mulState_d = bRegIsZero ? MD_FIX : MD_STEP;
				if (bRegIsZero) begin
					prodNeg_d = 1'b0;
					mq_d      = '0;
				end
			end
			MD_STEP: begin
				acc_d = mulSum[DATA_W:1];
				mq_d  = {mulSum[0], mq_q[DATA_W-1:1]};
				if (shiftLast) mulState_d = MD_FIX;
			end
			MD_FIX:  mulState_d = MD_DONE;
			MD_DONE: mulState_d = MD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mulState_q <= MD_IDLE;
			mcand_q    <= '0;
			mq_q       <= '0;
			acc_q      <= '0;
			origA_q    <= '0;
			prodNeg_q  <= 1'b0;
		end else if (clkEn) begin
			mulState_q <= mulState_d;
			mcand_q    <= mcand_d;
			mq_q       <= mq_d;
			acc_q      <= acc_d;
			origA_q    <= origA_d;
			prodNeg_q  <= prodNeg_d;
		end
	end

	// ======================================================================
	// Divide datapath and sequencer
	logic [DATA_W-1:0]   dvs_q, dvs_d, rem_q, rem_d;
	logic [OMB_MAG_W-1:0] quo_q, quo_d;
	logic                dvdNeg_q, dvdNeg_d, quoNeg_q, quoNeg_d, divOvf_q, divOvf_d;
	logic [2*DATA_W-2:0] dvdIn, dvdMag;
	logic [DATA_W:0]     trial;
	logic                trialFits;

	// Dividend is sign and thirty magnitude bits spread over A and B
	assign dvdIn     = {aReg, bReg[OMB_MAG_W-1:0]};
	assign dvdMag    = aReg[DATA_W-1] ? (~dvdIn + 1'b1) : dvdIn;
	assign trial     = {rem_q, quo_q[OMB_MAG_W-1]};
	assign trialFits = trial >= {1'b0, dvs_q};

	always_comb begin
		divState_d = divState_q;
		dvs_d      = dvs_q;
		rem_d      = rem_q;
		quo_d      = quo_q;
		dvdNeg_d   = dvdNeg_q;
		quoNeg_d   = quoNeg_q;
		divOvf_d   = divOvf_q;
		unique case (divState_q)
			DV_IDLE: if (startDiv && !startMul && mulState_q == MD_IDLE) divState_d = DV_LOAD;
			DV_LOAD: begin
				dvs_d      = memOperand[DATA_W-1] ? DATA_W'(-memOperand) : memOperand;
				rem_d      = dvdMag[2*DATA_W-2:OMB_MAG_W];
				quo_d      = dvdMag[OMB_MAG_W-1:0];
				dvdNeg_d   = aReg[DATA_W-1];
				quoNeg_d   = aReg[DATA_W-1] ^ memOperand[DATA_W-1];
				divState_d = DV_CHECK;
			end
			DV_CHECK: begin
				// High part not below divisor means a quotient past fifteen bits
				divOvf_d   = rem_q >= dvs_q;
				divState_d = divOvf_d ? DV_WRITE : DV_STEP;
			end
			DV_STEP: begin
				rem_d = trialFits ? DATA_W'(trial - {1'b0, dvs_q}) : trial[DATA_W-1:0];
				quo_d = {quo_q[OMB_MAG_W-2:0], trialFits};
				if (shiftLast) divState_d = DV_WRITE;
			end
			DV_WRITE: divState_d = DV_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			divState_q <= DV_IDLE;
			dvs_q      <= '0;
			rem_q      <= '0;
			quo_q      <= '0;
			dvdNeg_q   <= 1'b0;
			quoNeg_q   <= 1'b0;
			divOvf_q   <= 1'b0;
		end else if (clkEn) begin
			divState_q <= divState_d;
			dvs_q      <= dvs_d;
			rem_q      <= rem_d;
			quo_q      <= quo_d;
			dvdNeg_q   <= dvdNeg_d;
			quoNeg_q   <= quoNeg_d;
			divOvf_q   <= divOvf_d;
		end
	end

	// ======================================================================
	// Result write-back and host strobes
	logic [DATA_W-1:0] aResult_d, bResult_d, quoFull, remSigned;
	logic aLoadN_d, bLoadN_d, ovfN_d, lowEnN_d, highEnN_d;

	assign quoFull   = {1'b0, quo_q};
	assign remSigned = dvdNeg_q ? DATA_W'(-rem_q) : rem_q;

	always_comb begin
		aResult_d = aResult_q;
		bResult_d = bResult_q;
		aLoadN_d  = 1'b1;
		bLoadN_d  = 1'b1;
		ovfN_d    = 1'b1;
		// Adder low pair for multiply and divide steps, high pair for divide steps only
		lowEnN_d  = !(mulState_d == MD_STEP || divState_d == DV_STEP);
		highEnN_d = !(divState_d == DV_STEP);
		if (mulState_q == MD_FIX) begin
			aResult_d = mulRes[2*DATA_W-2:OMB_MAG_W];
			bResult_d = {1'b0, mulRes[OMB_MAG_W-1:0]};
			aLoadN_d  = 1'b0;
			bLoadN_d  = 1'b0;
			ovfN_d    = !mulOvf;
		end else if (divState_q == DV_WRITE) begin
			// On overflow the registers keep the dividend untouched
			ovfN_d = !divOvf_q;
			if (!divOvf_q) begin
				bResult_d = quoNeg_q ? DATA_W'(-quoFull) : quoFull;
				aResult_d = {dvdNeg_q, remSigned[OMB_MAG_W-1:0]};
				aLoadN_d  = 1'b0;
				bLoadN_d  = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aResult_q                <= '0;
			bResult_q                <= '0;
			aLoadN_q                 <= 1'b1;
			bLoadN_q                 <= 1'b1;
			overflowSetEnableN_q     <= 1'b1;
			adderSelectPairLowEnN_q  <= 1'b1;
			adderSelectPairHighEnN_q <= 1'b1;
			mdBusy_q                 <= 1'b0;
		end else if (clkEn) begin
			aResult_q                <= aResult_d;
			bResult_q                <= bResult_d;
			aLoadN_q                 <= aLoadN_d;
			bLoadN_q                 <= bLoadN_d;
			overflowSetEnableN_q     <= ovfN_d;
			adderSelectPairLowEnN_q  <= lowEnN_d;
			adderSelectPairHighEnN_q <= highEnN_d;
			mdBusy_q                 <= (mulState_d != MD_IDLE) || (divState_d != DV_IDLE);
		end
	end

	// ======================================================================
	// Bit test and skip sequencer
	omb_test_seq #(.DATA_W(DATA_W)) u_test (
		.ref_clk          (ref_clk),
		.reset            (reset),
		.clkEn            (clkEn),
		.startBt          (startBt),
		.startSre         (startSre),
		.bitSel           (bitSel),
		.bitRegSelB       (bitRegSelB),
		.bitExpect        (bitExpect),
		.sreSel           (sreSel),
		.adderASideInN    (adderASideInN),
		.adderInputsEqual (adderInputsEqual),
		.gateAN_q         (gateAN_q),
		.gateBN_q         (gateBN_q),
		.gateXN_q         (gateXN_q),
		.jumpN_q          (jumpN_q),
		.skipN_q          (skipN_q),
		.pIncN_q          (pIncN_q),
		.testBusy_q       (testBusy_q)
	);

	// ======================================================================
	// Checks
	a_mul_ovf_flag: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && mulState_q == MD_FIX |=> overflowSetEnableN_q == !$past(mulOvf))
		else $error("multiply overflow enable wrong");
	a_mul_b_sign: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && mulState_q == MD_FIX |=> !bLoadN_q && !bResult_q[DATA_W-1])
		else $error("multiply left B sign set");
	a_div_refuse: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && divState_q == DV_WRITE && divOvf_q |=> !overflowSetEnableN_q && bLoadN_q)
		else $error("divide overflow not flagged or result loaded");
	a_div_a_sign: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && divState_q == DV_WRITE && !divOvf_q |=> aResult_q[DATA_W-1] == dvdNeg_q)
		else $error("remainder sign differs from dividend sign");
	a_shift_mul_end: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && mulState_q == MD_STEP && shiftLast |=> mulState_q == MD_FIX)
		else $error("multiply did not end on last shift");
	a_shift_div_en: assert property (@(posedge ref_clk) disable iff (reset)
		divState_q == DV_STEP |-> shiftEn && shiftLimit == OMB_DIV_STEPS)
		else $error("divide step without shift counter");
	a_adder_sel_mul: assert property (@(posedge ref_clk) disable iff (reset)
		mulState_q == MD_STEP |-> !adderSelectPairLowEnN_q && adderSelectPairHighEnN_q)
		else $error("adder select enables wrong in multiply");
	a_reset_idle: assert property (@(posedge ref_clk)
		reset |=> mulState_q == MD_IDLE && divState_q == DV_IDLE && !mdBusy_q)
		else $error("sequencers not idle after reset");

endmodule // omb_unit

// ==== verif/omb_host_model.sv ====
// Host processor model: register gating onto the adder A side
`timescale 1ns/10ps
module omb_host_model (
	// Clock
	input  wire logic        ref_clk,
	// Gates from the unit
	input  wire logic        gateAN,
	input  wire logic        gateBN,
	input  wire logic        gateXN,
	// Host registers
	input  wire logic [15:0] aReg,
	input  wire logic [15:0] bReg,
	input  wire logic [15:0] xReg,
	input  wire logic [15:0] memOperand,
	// Adder view towards the unit
	output logic [15:0]      adderASideInN,
	output logic             adderInputsEqual,
	output logic             bRegIsZero
);
	logic [15:0] lastN_q = 16'h0000;
	logic [15:0] val;
	logic        idle;
	// ======================================================================
	// Ungated bus toggles every cycle so a stale value is never trusted
	always_comb begin
		idle = gateAN & gateBN & gateXN;
		val = !gateAN ? aReg : (!gateBN ? bReg : xReg);
		adderASideInN = idle ? ~lastN_q : ~val;
		adderInputsEqual = !idle && (val == memOperand);
		bRegIsZero = (bReg == 16'h0000);
	end
	// Last bus value
	always_ff @(posedge ref_clk) lastN_q <= adderASideInN;
endmodule // omb_host_model

// ==== verif/omb_unit_tb_top.sv ====
// Testbench for the multiply, divide, bit test and skip unit
`timescale 1ns/10ps
module omb_unit_tb_top;
	logic ref_clk = 0, reset = 1, clkEn = 1, bitRegSelB = 0, bitExpect = 0;
	logic multiplyDecodeN = 1, divideDecodeN = 1, bitTestJumpN = 1, skipOnRegisterEqualN = 1;
	logic [3:0] bitSel = 0;
	logic [1:0] sreSel = 0;
	logic [15:0] aReg = 0, bReg = 0, xReg = 0, memOperand = 0, adderASideInN, aResult_q, bResult_q;
	logic adderInputsEqual, bRegIsZero, aLoadN_q, bLoadN_q, overflowSetEnableN_q, mdBusy_q;
	logic adderSelectPairLowEnN_q, adderSelectPairHighEnN_q, gateAN_q, gateBN_q, gateXN_q;
	logic jumpN_q, skipN_q, pIncN_q, testBusy_q;
	int errorCnt = 0, testsRun = 0, cyc = 0;
	// ======================================================================
	// Design, host model and clock
	omb_unit dut (.ref_clk, .reset, .clkEn, .multiplyDecodeN, .divideDecodeN, .bitTestJumpN,
		.skipOnRegisterEqualN, .bitSel, .bitRegSelB, .bitExpect, .sreSel, .aReg, .bReg,
		.memOperand, .adderASideInN, .adderInputsEqual, .bRegIsZero, .aResult_q, .bResult_q,
		.aLoadN_q, .bLoadN_q, .overflowSetEnableN_q, .adderSelectPairLowEnN_q,
		.adderSelectPairHighEnN_q, .mdBusy_q, .gateAN_q, .gateBN_q, .gateXN_q, .jumpN_q,
		.skipN_q, .pIncN_q, .testBusy_q);
	omb_host_model host (.ref_clk, .gateAN(gateAN_q), .gateBN(gateBN_q), .gateXN(gateXN_q),
		.aReg, .bReg, .xReg, .memOperand, .adderASideInN, .adderInputsEqual, .bRegIsZero);
	always #20 ref_clk = ~ref_clk;
	// ======================================================================
	// Checking and closing
	task chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wrapUp();
		$display("checks=%0d mismatches=%0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errorCnt++;
			wrapUp();
		end
	end
	// ======================================================================
	// Multiply or divide; results sampled while the load strobes are low
	task md(input logic dv, input logic [15:0] a, input logic [15:0] b, input logic [15:0] r);
		longint x, y;
		logic o, ld, en, eo;
		logic [15:0] ra, rb, ea, eb;
		aReg <= a;
		bReg <= b;
		memOperand <= r;
		@(posedge ref_clk);
		if (dv) divideDecodeN <= 0;
		else multiplyDecodeN <= 0;
		@(posedge ref_clk);
		{divideDecodeN, multiplyDecodeN} <= 2'h3;
		{o, ld, en} = 3'h0;
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			o |= !overflowSetEnableN_q;
			en |= !adderSelectPairLowEnN_q;
			if (!aLoadN_q) {ld, ra, rb} = {1'b1, aResult_q, bResult_q};
		end
		if (dv) begin
			// Signed dividend and divisor; overflow is judged on magnitudes
			x = $signed({a, b[14:0]});
			y = $signed(r);
			eo = ((x < 0 ? -x : x) >> 15) >= (y < 0 ? -y : y);
			{ea, eb} = {a[15], 15'(x % y), 16'(x / y)};
		end else begin
			x = $signed(r) * $signed(b) + $signed(a);
			eo = x > 64'sh3fffffff || x < -64'sh40000000;
			{ea, eb} = {x[30:15], 1'b0, x[14:0]};
		end
		chk(o, eo);
		chk(ld, !(dv && eo));
		if (ld) chk({ra, rb}, {ea, eb});
		chk({en, mdBusy_q}, {dv ? !eo : b != 0, 1'b0});
		@(posedge ref_clk);
		$display("md done dv=%h a=%h b=%h r=%h", dv, a, b, r);
	endtask
	// ======================================================================
	// Bit test or register-equal skip; outcome and gates gathered over the window
	task ts(input logic sk, input logic [1:0] s, input logic [3:0] p, input logic e);
		logic [15:0] v;
		logic j, n, k;
		logic [2:0] g;
		{bitRegSelB, bitSel, bitExpect, sreSel} <= {s[0], p, e, s};
		@(posedge ref_clk);
		if (sk) skipOnRegisterEqualN <= 0;
		else bitTestJumpN <= 0;
		@(posedge ref_clk);
		{skipOnRegisterEqualN, bitTestJumpN} <= 2'h3;
		{j, n, k, g} = 6'h00;
		repeat (8) begin
			@(posedge ref_clk);
			#1;
			{j, n, k} = {j, n, k} | {!jumpN_q, !pIncN_q, !skipN_q};
			g |= ~{gateAN_q, gateBN_q, gateXN_q};
		end
		v = (s == 0) ? aReg : ((s == 1) ? bReg : xReg);
		if (sk) chk({k, j, n}, {v == memOperand, 2'h0});
		else chk({j, n, k}, {v[p] == e, v[p] != e, 1'b0});
		chk({g, testBusy_q}, {3'h4 >> s, 1'b0});
		@(posedge ref_clk);
		$display("test done sk=%h s=%h", sk, s);
	endtask
	// ======================================================================
	// Clock enable low freezes a running multiply; it resumes where it stopped
	task frz();
		logic ld;
		aReg <= 16'h0002;
		bReg <= 16'h0004;
		memOperand <= 16'h0005;
		multiplyDecodeN <= 0;
		@(posedge ref_clk);
		multiplyDecodeN <= 1;
		repeat (3) @(posedge ref_clk);
		clkEn <= 0;
		repeat (30) @(posedge ref_clk);
		clkEn <= 1;
		#1;
		chk({mdBusy_q, aLoadN_q}, 2'h3);
		ld = 0;
		repeat (20) begin
			@(posedge ref_clk);
			#1;
			if (!aLoadN_q) ld = (aResult_q == 16'h0000) && (bResult_q == 16'h0016);
		end
		chk({ld, mdBusy_q}, 2'h2);
		@(posedge ref_clk);
		$display("freeze test done");
	endtask
	// ======================================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 0;
		md(0, 16'h0007, 16'h0005, 16'h0003);
		md(0, 16'h0000, 16'h0003, 16'hfffe);
		md(0, 16'h0000, 16'h8000, 16'h8000);
		md(0, 16'h0009, 16'h0000, 16'h0005);
		md(1, 16'h0001, 16'h0005, 16'h0100);
		md(1, 16'h0100, 16'h0000, 16'h0100);
		md(1, 16'hffff, 16'h7ff9, 16'h0003);
		md(1, 16'hffff, 16'h7ff9, 16'hfffd);
		{aReg, bReg, xReg} <= {16'h1234, 16'h8001, 16'h00aa};
		ts(0, 0, 4'h2, 1);
		ts(0, 0, 4'h0, 1);
		ts(0, 1, 4'hf, 1);
		ts(0, 1, 4'h1, 1);
		memOperand <= 16'h1234;
		ts(1, 0, 0, 0);
		ts(1, 1, 0, 0);
		memOperand <= 16'h00aa;
		ts(1, 2, 0, 0);
		frz();
		// Reset in mid-multiply must drop the operation; a fresh one then runs clean
		multiplyDecodeN <= 0;
		repeat (5) @(posedge ref_clk);
		{multiplyDecodeN, reset} <= 2'h3;
		@(posedge ref_clk);
		reset <= 0;
		#1;
		chk({mdBusy_q, aLoadN_q}, 2'h1);
		@(posedge ref_clk);
		md(0, 16'h0001, 16'h0002, 16'h0003);
		wrapUp();
	end
endmodule // omb_unit_tb_top
